// >>> sfic_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the interrupt wire
// ----------------------------------------
module sfic_host_model (
    input wire logic irq_pin_level,
    input wire logic irq_pin_oe_n,
    input wire logic irq_polarity,
    output logic irq_wire,
    output logic irq_seen
);
    // Board pull-up wins whenever the pin is released
    assign irq_wire = irq_pin_oe_n ? 1'b1 : irq_pin_level;
    // Host compares the wire against the level it configured
    assign irq_seen = (irq_wire === irq_polarity);
endmodule

// >>> sfic_pkg.sv
// What this block does
// R01: Width select maps codes to 6..14 bits
// R02: Queue enabled caps 14-bit to 12-bit
// R03: Range field selects full-scale range
// R04: Results sign-extended into output registers 0x02-0x07
// R05: Software programs threshold 1 to 31
// R06: Queue functions need enable, except clear
// R07: Disabled queue flags report default values
// R08: Policy 0 writes while entries free
// R09: Policy 1 stops at threshold level
// R10: Disabled writes outputs, enabled writes queue
// R11: Clear bit zeroes pointers and entries
// R12: Queue writes gated by enable bit
// R13: Drive type selects open-drain or push-pull
// R14: Polarity bit sets asserted pin level
// R15: Wake event raises interrupt when enabled
// R16: New sample raises interrupt when enabled
// R17: Empty interrupt only at count zero
// R18: Full interrupt only at count 32
// R19: Threshold interrupt at programmed level
// R20: Combined activity interrupt only in combined mode
// R21: Enabled pending sources ORed onto pin
package sfic_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_OUT_FIRST = 8'h02;
    localparam logic [7:0] ADDR_OUT_LAST = 8'h07;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RANGE_RES = 8'h15;
    localparam logic [7:0] ADDR_QUEUE_CTL = 8'h16;
    localparam logic [7:0] ADDR_IRQ_CTL = 8'h17;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // ----------------------------------------
    // Queue geometry
    // ----------------------------------------
    localparam int QUEUE_DEPTH = 32;
    localparam int QUEUE_WIDTH = 12;
    localparam logic [5:0] QUEUE_FULL_COUNT = 6'h20;
    localparam logic [3:0] WIDTH_MAX_QUEUE = 4'hc;
    localparam logic [2:0] WSEL_14BIT = 3'h5;
    // ----------------------------------------
    // Status bit positions (own layout)
    // ----------------------------------------
    localparam int ST_NEW_DATA = 0;
    localparam int ST_EMPTY = 1;
    localparam int ST_FULL = 2;
    localparam int ST_THRESH = 3;
    localparam logic [7:0] STATUS_DEFAULT = 8'h02;

    typedef struct packed {
        logic rsv7;
        logic [2:0] range_select;
        logic rsv3;
        logic [2:0] sample_width_select;
    } sfic_range_t;

    typedef struct packed {
        logic queue_clear;
        logic queue_enable;
        logic overflow_policy;
        logic [4:0] queue_threshold_level;
    } sfic_qctl_t;

    typedef struct packed {
        logic combined_activity_irq_enable;
        logic queue_level_irq_enable;
        logic queue_full_irq_enable;
        logic queue_empty_irq_enable;
        logic new_sample_irq_enable;
        logic wake_irq_enable;
        logic irq_polarity;
        logic irq_drive_type;
    } sfic_irqctl_t;

    typedef struct packed {
        logic [2:0] axis;
        logic [13:0] value;
    } sfic_sample_t;
endpackage

// >>> sfic_top.sv
`timescale 1ns/1ps
module sfic_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic [13:0] sample_x,
    input wire logic [13:0] sample_y,
    input wire logic [13:0] sample_z,
    input wire logic wake_event,
    input wire logic activity_event,
    input wire logic combined_watch_active_mode,
    output logic [2:0] range_select,
    output logic irq_pin_level,
    output logic irq_pin_oe_n
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        sfic_pkg::sfic_range_t rng;
        sfic_pkg::sfic_qctl_t qctl;
        sfic_pkg::sfic_irqctl_t ictl;
        logic [7:0] rdata;
        logic [2:0][13:0] outreg;
        logic [4:0] wptr;
        logic [4:0] rptr;
        logic [5:0] count;
        logic new_data;
        logic wake_pend;
        logic act_pend;
        logic pin_o;
        logic pin_oe_n;
    } sfic_state_t;

    sfic_state_t st_ff;
    sfic_state_t nxt_st;
    logic [2:0][11:0] queue_mem_ff [sfic_pkg::QUEUE_DEPTH];
    logic [3:0] width_bits;
    logic [3:0] eff_width;
    logic [2:0][13:0] shaped;
    logic queue_write;
    logic queue_read;
    logic [7:0] status;
    logic irq_any;

    // Width decode, reserved codes fall back to 6 bits
    always_comb
    begin
        case (st_ff.rng.sample_width_select) // [R01]
            3'h0: width_bits = 4'h6;
            3'h1: width_bits = 4'h7;
            3'h2: width_bits = 4'h8;
            3'h3: width_bits = 4'ha;
            3'h4: width_bits = 4'hc;
            3'h5: width_bits = 4'he;
            default: width_bits = 4'h6;
        endcase
        if (st_ff.qctl.queue_enable && st_ff.rng.sample_width_select == sfic_pkg::WSEL_14BIT)
        begin
            eff_width = sfic_pkg::WIDTH_MAX_QUEUE; // [R02]
        end
        else
        begin
            eff_width = width_bits;
        end
    end

    // Truncate to width, then sign-extend
    function automatic logic [13:0] shape(input logic [13:0] raw, input logic [3:0] w);
        logic [13:0] r;
        r = raw;
        for (int b = 0; b < 14; b++)
        begin
            if (b >= 32'(w))
            begin
                r[b] = raw[w - 4'h1]; // [R04]
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // Queue control
    // ----------------------------------------
    // Write strobe is the clock gate: no enable, no write activity
    always_comb
    begin
        shaped[0] = shape(sample_x, eff_width);
        shaped[1] = shape(sample_y, eff_width);
        shaped[2] = shape(sample_z, eff_width);
        queue_write = sample_valid && st_ff.qctl.queue_enable // [R12] [R06]
            && st_ff.count != sfic_pkg::QUEUE_FULL_COUNT // [R08]
            && !(st_ff.qctl.overflow_policy
                 && st_ff.count >= {1'b0, st_ff.qctl.queue_threshold_level}); // [R09]
        queue_read = reg_rd && st_ff.qctl.queue_enable && st_ff.count != 6'h00
            && reg_addr == sfic_pkg::ADDR_OUT_LAST;
    end

    // Queue flags report defaults while the queue is off; new-data stays live
    always_comb
    begin
        status = sfic_pkg::STATUS_DEFAULT; // [R07]
        status[sfic_pkg::ST_NEW_DATA] = st_ff.new_data;
        if (st_ff.qctl.queue_enable)
        begin
            status[sfic_pkg::ST_EMPTY] = st_ff.count == 6'h00;
            status[sfic_pkg::ST_FULL] = st_ff.count == sfic_pkg::QUEUE_FULL_COUNT;
            status[sfic_pkg::ST_THRESH] = st_ff.count >= {1'b0, st_ff.qctl.queue_threshold_level};
        end
    end

    // Threshold 0 is software's fault; it then trips at once
    always_comb
    begin
        irq_any = (st_ff.ictl.new_sample_irq_enable && st_ff.new_data) // [R16] [R21]
            || (st_ff.ictl.wake_irq_enable && st_ff.wake_pend) // [R15]
            || (st_ff.ictl.combined_activity_irq_enable && st_ff.act_pend); // [R20]
        if (st_ff.qctl.queue_enable) // [R06]
        begin
            irq_any = irq_any
                || (st_ff.ictl.queue_empty_irq_enable && st_ff.count == 6'h00) // [R17]
                || (st_ff.ictl.queue_full_irq_enable && st_ff.count == sfic_pkg::QUEUE_FULL_COUNT) // [R18]
                || (st_ff.ictl.queue_level_irq_enable
                    && st_ff.count >= {1'b0, st_ff.qctl.queue_threshold_level}); // [R19] [R05]
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rdata = 8'h00;
        if (reg_wr)
        begin
            if (reg_addr == sfic_pkg::ADDR_RANGE_RES)
            begin
                nxt_st.rng = reg_wdata; // [R03]
                nxt_st.rng.rsv7 = 1'b0;
                nxt_st.rng.rsv3 = 1'b0;
            end
            else if (reg_addr == sfic_pkg::ADDR_QUEUE_CTL)
            begin
                nxt_st.qctl = reg_wdata;
            end
            else if (reg_addr == sfic_pkg::ADDR_IRQ_CTL)
            begin
                nxt_st.ictl = reg_wdata;
            end
        end
        if (reg_rd)
        begin
            if (reg_addr >= sfic_pkg::ADDR_OUT_FIRST && reg_addr <= sfic_pkg::ADDR_OUT_LAST)
            begin
                nxt_st.rdata = reg_addr[0]
                    ? {{2{st_ff.outreg[3'(reg_addr - 8'h02) >> 1][13]}},
                       st_ff.outreg[3'(reg_addr - 8'h02) >> 1][13:8]} // [R04]
                    : st_ff.outreg[3'(reg_addr - 8'h02) >> 1][7:0];
            end
            else if (reg_addr == sfic_pkg::ADDR_STATUS)
            begin
                nxt_st.rdata = status;
                nxt_st.new_data = 1'b0;
                nxt_st.wake_pend = 1'b0;
                nxt_st.act_pend = 1'b0;
            end
            else if (reg_addr == sfic_pkg::ADDR_RANGE_RES)
            begin
                nxt_st.rdata = st_ff.rng;
            end
            else if (reg_addr == sfic_pkg::ADDR_QUEUE_CTL)
            begin
                nxt_st.rdata = st_ff.qctl;
            end
            else if (reg_addr == sfic_pkg::ADDR_IRQ_CTL)
            begin
                nxt_st.rdata = st_ff.ictl;
            end
        end
        // Set wins over read-clear
        if (wake_event)
        begin
            nxt_st.wake_pend = 1'b1;
        end
        if (activity_event && combined_watch_active_mode)
        begin
            nxt_st.act_pend = 1'b1; // [R20]
        end
        if (sample_valid && (queue_write || !st_ff.qctl.queue_enable))
        begin
            nxt_st.new_data = 1'b1; // [R16]
        end
        if (sample_valid && !st_ff.qctl.queue_enable)
        begin
            nxt_st.outreg[0] = shape(sample_x, eff_width); // [R10]
            nxt_st.outreg[1] = shape(sample_y, eff_width);
            nxt_st.outreg[2] = shape(sample_z, eff_width);
        end
        if (queue_read)
        begin
            for (int a = 0; a < 3; a++)
            begin
                nxt_st.outreg[a] = {{2{queue_mem_ff[st_ff.rptr][a][11]}}, queue_mem_ff[st_ff.rptr][a]};
            end
            nxt_st.rptr = st_ff.rptr + 5'h01;
        end
        if (queue_write)
        begin
            nxt_st.wptr = st_ff.wptr + 5'h01; // [R10]
        end
        nxt_st.count = st_ff.count + {5'h00, queue_write} - {5'h00, queue_read};
        if (st_ff.qctl.queue_clear)
        begin
            nxt_st.wptr = 5'h00; // [R11]
            nxt_st.rptr = 5'h00;
            nxt_st.count = 6'h00;
            nxt_st.qctl.queue_clear = 1'b0;
        end
        // Polarity sets level; open-drain only pulls low
        nxt_st.pin_o = irq_any ~^ st_ff.ictl.irq_polarity; // [R14]
        nxt_st.pin_oe_n = st_ff.ictl.irq_drive_type ? 1'b0 : !(irq_any ^ st_ff.ictl.irq_polarity); // [R13]
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
            st_ff.pin_o <= 1'b1;
            st_ff.pin_oe_n <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Entries zeroed on clear; one cycle after the write, not truly async
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < sfic_pkg::QUEUE_DEPTH; i++)
            begin
                queue_mem_ff[i] <= '0;
            end
        end
        else if (st_ff.qctl.queue_clear)
        begin
            for (int i = 0; i < sfic_pkg::QUEUE_DEPTH; i++)
            begin
                queue_mem_ff[i] <= '0; // [R11]
            end
        end
        else if (queue_write)
        begin
            queue_mem_ff[st_ff.wptr] <= {shaped[2][11:0], shaped[1][11:0], shaped[0][11:0]}; // [R02]
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign range_select = st_ff.rng.range_select;
    assign irq_pin_level = st_ff.pin_o;
    assign irq_pin_oe_n = st_ff.pin_oe_n;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_full_stop;
        @(posedge sys_clk) disable iff (!arst_n)
        st_ff.count == sfic_pkg::QUEUE_FULL_COUNT && !queue_read && !st_ff.qctl.queue_clear
        |=> st_ff.count == sfic_pkg::QUEUE_FULL_COUNT;
    endproperty
    a_full_stop: assert property (p_full_stop) else $error("queue overfilled"); // [R08]

    property p_watermark;
        @(posedge sys_clk) disable iff (!arst_n)
        st_ff.qctl.overflow_policy && st_ff.count >= {1'b0, st_ff.qctl.queue_threshold_level} |-> !queue_write;
    endproperty
    a_watermark: assert property (p_watermark) else $error("write past watermark"); // [R09]

    property p_gate;
        @(posedge sys_clk) disable iff (!arst_n)
        !st_ff.qctl.queue_enable |-> !queue_write;
    endproperty
    a_gate: assert property (p_gate) else $error("write while disabled"); // [R12]

    property p_clear;
        @(posedge sys_clk) disable iff (!arst_n)
        st_ff.qctl.queue_clear |=> st_ff.count == 6'h00 && st_ff.wptr == 5'h00 && !st_ff.qctl.queue_clear;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed"); // [R11]

    property p_status_default;
        @(posedge sys_clk) disable iff (!arst_n)
        reg_rd && reg_addr == sfic_pkg::ADDR_STATUS && !st_ff.qctl.queue_enable
        |=> reg_rdata[3:1] == sfic_pkg::STATUS_DEFAULT[3:1];
    endproperty
    a_status_default: assert property (p_status_default) else $error("status not default"); // [R07]

    property p_pushpull;
        @(posedge sys_clk) disable iff (!arst_n)
        st_ff.ictl.irq_drive_type && $stable(st_ff.ictl) |=> !irq_pin_oe_n;
    endproperty
    a_pushpull: assert property (p_pushpull) else $error("push-pull not driving"); // [R13]

    property p_polarity;
        @(posedge sys_clk) disable iff (!arst_n)
        irq_any && st_ff.ictl.irq_drive_type |=> irq_pin_level == $past(st_ff.ictl.irq_polarity);
    endproperty
    a_polarity: assert property (p_polarity) else $error("wrong pin level"); // [R14] [R21]

    property p_empty_irq;
        @(posedge sys_clk) disable iff (!arst_n)
        st_ff.qctl.queue_enable && st_ff.ictl.queue_empty_irq_enable && st_ff.count == 6'h00 |-> irq_any;
    endproperty
    a_empty_irq: assert property (p_empty_irq) else $error("empty irq missing"); // [R17]

    property p_new_sample;
        @(posedge sys_clk) disable iff (!arst_n)
        sample_valid && !st_ff.qctl.queue_enable |=> st_ff.new_data;
    endproperty
    a_new_sample: assert property (p_new_sample) else $error("new data lost"); // [R16]

    property p_sign_hi;
        @(posedge sys_clk) disable iff (!arst_n)
        reg_rd && reg_addr >= sfic_pkg::ADDR_OUT_FIRST && reg_addr <= sfic_pkg::ADDR_OUT_LAST && reg_addr[0]
        |=> reg_rdata[7:6] == {2{reg_rdata[5]}};
    endproperty
    a_sign_hi: assert property (p_sign_hi) else $error("high byte not sign-extended"); // [R04]

    property p_width_cap;
        @(posedge sys_clk) disable iff (!arst_n)
        st_ff.qctl.queue_enable |-> eff_width <= sfic_pkg::WIDTH_MAX_QUEUE;
    endproperty
    a_width_cap: assert property (p_width_cap) else $error("queue width above cap"); // [R02]

    c_full: cover property (@(posedge sys_clk) st_ff.count == sfic_pkg::QUEUE_FULL_COUNT);
    c_clear: cover property (@(posedge sys_clk) st_ff.qctl.queue_clear && st_ff.count != 6'h00);
    c_irq: cover property (@(posedge sys_clk) !irq_pin_oe_n && st_ff.ictl.irq_polarity);
    c_watermark: cover property (@(posedge sys_clk) st_ff.qctl.overflow_policy && sample_valid && !queue_write);
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sample_valid = 1'b0;
    logic [13:0] sx = 14'h0000;
    logic [13:0] sy = 14'h0000;
    logic [13:0] sz = 14'h0000;
    logic wake_event = 1'b0;
    logic activity_event = 1'b0;
    logic cmode = 1'b0;
    logic [2:0] range_select;
    logic irq_pin_level;
    logic irq_pin_oe_n;
    logic pol = 1'b0;
    logic irq_wire;
    logic irq_seen;
    int miscompares = 0;
    int num_checks = 0;
    logic [7:0] d;
    logic [15:0] e;
    int widths [6] = '{6, 7, 8, 10, 12, 14};
    int seed;

    always #2 sys_clk = ~sys_clk;

    sfic_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
        .sample_x(sx), .sample_y(sy), .sample_z(sz), .wake_event(wake_event),
        .activity_event(activity_event), .combined_watch_active_mode(cmode),
        .range_select(range_select), .irq_pin_level(irq_pin_level), .irq_pin_oe_n(irq_pin_oe_n));

    sfic_host_model host (.irq_pin_level(irq_pin_level), .irq_pin_oe_n(irq_pin_oe_n), .irq_polarity(pol),
        .irq_wire(irq_wire), .irq_seen(irq_seen));

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp, msg);
    endtask

    task automatic send(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
        @(posedge sys_clk);
        sx <= x;
        sy <= y;
        sz <= z;
        sample_valid <= 1'b1;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
    endtask

    // Pin follows its cause two cycles late; leave margin
    task automatic irqc(input logic exp, input string msg);
        repeat (4) @(posedge sys_clk);
        #1 chk({7'h00, irq_seen}, {7'h00, exp}, msg);
    endtask

    task automatic pulse_ev(input logic wake);
        @(posedge sys_clk);
        wake_event <= wake;
        activity_event <= ~wake;
        @(posedge sys_clk);
        wake_event <= 1'b0;
        activity_event <= 1'b0;
    endtask

    function automatic logic [15:0] ext(input logic [13:0] v, input int w);
        logic signed [15:0] t;
        t = signed'({2'b00, v} << (16 - w));
        return 16'(t >>> (16 - w));
    endfunction

    task automatic close_out();
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #40us;
        miscompares++;
        close_out();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        seed = $urandom(32'haa9a);
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        rdc(8'h15, 8'h00, "range reset");
        rdc(8'h16, 8'h00, "queue ctl reset");
        rdc(8'h17, 8'h00, "irq ctl reset");
        rdc(8'h08, sfic_pkg::STATUS_DEFAULT, "status default");
        wr(8'h40, 8'h5a);
        rdc(8'h40, 8'h00, "unmapped");
        wr(8'h15, 8'hff);
        rdc(8'h15, 8'h77, "reserved bits");
        // Direct path, every width code except reserved 6 and 7
        for (int c = 0; c < 6; c++)
        begin
            d = {1'b0, 3'($urandom % 5), 1'b0, 3'(c)};
            wr(8'h15, d);
            #1 chk({5'h00, range_select}, {5'h00, d[6:4]}, "range out");
            send(14'($urandom), 14'($urandom), 14'($urandom));
            repeat (2) @(posedge sys_clk);
            e = ext(sx, widths[c]);
            rdc(8'h02, e[7:0], "x lo");
            rd(8'h03, d);
            chk(d, e[15:8], "x hi");
            e = ext(sy, widths[c]);
            rdc(8'h04, e[7:0], "y lo");
            e = ext(sz, widths[c]);
            rdc(8'h06, e[7:0], "z lo");
        end
        // Queue caps the widest code at 12 bits
        wr(8'h16, 8'h41);
        send(14'h2abc, 14'h0123, 14'h3fff);
        rd(8'h07, d);
        rdc(8'h02, 8'hbc, "capped lo");
        rdc(8'h03, 8'hfa, "capped hi");
        // Queue disabled keeps queue interrupts quiet
        wr(8'h16, 8'h00);
        pol <= 1'b1;
        wr(8'h17, 8'h13);
        irqc(1'b0, "empty irq while off");
        wr(8'h16, 8'h41);
        irqc(1'b1, "empty irq");
        // Fill to 32, then one too many
        wr(8'h17, 8'h23);
        for (int i = 0; i < 31; i++)
            send(14'($urandom), 14'($urandom), 14'($urandom));
        irqc(1'b0, "full early");
        send(14'h0001, 14'h0002, 14'h0003);
        send(14'h0004, 14'h0005, 14'h0006);
        irqc(1'b1, "full irq");
        rd(8'h08, d);
        chk({7'h00, d[sfic_pkg::ST_FULL]}, 8'h01, "full flag");
        wr(8'h16, 8'hc1);
        repeat (3) @(posedge sys_clk);
        rd(8'h08, d);
        chk({6'h00, d[sfic_pkg::ST_FULL], d[sfic_pkg::ST_EMPTY]}, 8'h01, "after clear");
        irqc(1'b0, "full irq gone");
        // Watermark policy stops at threshold 4
        wr(8'h17, 8'h43);
        wr(8'h16, 8'h64);
        for (int i = 0; i < 6; i++)
            send(14'($urandom), 14'($urandom), 14'($urandom));
        irqc(1'b1, "level irq");
        for (int i = 0; i < 4; i++)
            rd(8'h07, d);
        rd(8'h08, d);
        chk({7'h00, d[sfic_pkg::ST_EMPTY]}, 8'h01, "four stored");
        wr(8'h16, 8'h00);
        // New-sample source under all drive and polarity settings
        for (int m = 0; m < 4; m++)
        begin
            pol <= m[1];
            wr(8'h17, {4'h0, 2'b10, 2'(m)});
            rd(8'h08, d);
            irqc(1'b0, "idle pin");
            send(14'($urandom), 14'($urandom), 14'($urandom));
            irqc(1'b1, "new sample irq");
            if (m[0])
                chk({7'h00, irq_pin_oe_n}, 8'h00, "push-pull drives");
            rd(8'h08, d);
        end
        // Wake and combined-mode activity sources
        pol <= 1'b1;
        wr(8'h17, 8'h07);
        pulse_ev(1'b1);
        irqc(1'b1, "wake irq");
        rd(8'h08, d);
        irqc(1'b0, "wake cleared");
        wr(8'h17, 8'h83);
        pulse_ev(1'b0);
        irqc(1'b0, "activity outside mode");
        @(posedge sys_clk);
        cmode <= 1'b1;
        pulse_ev(1'b0);
        irqc(1'b1, "activity in mode");
        close_out();
    end
endmodule
